// >>> include/dac_loader_regs.vh
// register map, field positions and reset values of the dual dac frame loader
`ifndef DAC_LOADER_REGS_VH
`define DAC_LOADER_REGS_VH

// ----------------------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------------------
`define DL_CTRL_OFS       12'h000
`define DL_STAT_OFS       12'h004
`define DL_DACA_OFS       12'h008
`define DL_DACB_OFS       12'h00C
`define DL_HOLD_OFS       12'h010
`define DL_CFG_OFS        12'h014

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DL_CTRL_FREEZE    0
`define DL_STAT_OVF       0
`define DL_STAT_ACTIVE    1
`define DL_STAT_CNT_LO    2
`define DL_CFG_REF_LO     0
`define DL_CFG_FAST       2
`define DL_CFG_PWR        3
`define DL_CFG_REF_INT    4
`define DL_CFG_REF_HIGH   5

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define DL_FRAME_BITS     5'h10
`define DL_SEL_HI_BIT     15
`define DL_FAST_BIT       14
`define DL_PWR_BIT        13
`define DL_SEL_LO_BIT     12
`define DL_TGT_DAC_B      2'h0
`define DL_TGT_HOLD       2'h1
`define DL_TGT_DAC_A      2'h2
`define DL_TGT_CTRL       2'h3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DL_CODE_RST       12'h000
`define DL_CTRL_RST       1'h0

`endif

// >>> verilog/dual_dac_frame_loader.v
// serial frame loader of a dual 12-bit dac with apb status and control
//
// Summary of operation
// - shift msb first on serial clock falls
// - transfer after sixteen bits or select rise
// - word's own select bits pick destination latch
// - reset clears every latch to zero
// - dac codes are unsigned twelve bit values
// - latch update on sixteenth rising clock edge
// - bits 15..12 select, speed, power, select
// - 00 b+hold, 01 hold, 10 a+b<-hold, 11 ctrl
// - speed 1 fast; power 1 powers down
// - ref bits: 00/11 external, 01 low, 10 high
`timescale 1ns/10ps
`include "dac_loader_regs.vh"

module dual_dac_frame_loader #(
  parameter FIFO_DEPTH = 2,
  parameter FIFO_AW    = 1
) (
  input  wire        ref_clk_i,
  input  wire        rst_b_i,
  input  wire        sel_b_i,
  input  wire        sclk_i,
  input  wire        din_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire [11:0] dac_a_code_o,
  output wire [11:0] dac_b_code_o,
  output wire        fast_settle_o,
  output wire        power_down_o,
  output wire [1:0]  ref_source_sel_o,
  output wire        ref_internal_o,
  output wire        ref_high_o
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  // release is synchronous so every flop leaves reset on one edge
  reg        rst_s1_q;
  reg        rst_b_q;

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_b_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_b_q  <= rst_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  // din keeps a third stage: data may change just after the clock fall, so
  // the bit is taken from the sample one cycle older than the edge sample
  reg  [2:0] sel_q;
  reg  [2:0] sclk_q;
  reg  [2:0] din_q;
  // sel and sclk reset to their idle high level, so release fakes no edge

  always @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sel_q  <= 3'h7;
      sclk_q <= 3'h7;
      din_q  <= 3'h0;
    end else begin
      sel_q  <= {sel_q[1:0], sel_b_i};
      sclk_q <= {sclk_q[1:0], sclk_i};
      din_q  <= {din_q[1:0], din_i};
    end
  end

  // edges come from stages 2 and 1; stage 0 only settles metastability
  wire sel_fall  = sel_q[2] & ~sel_q[1];
  wire sel_rise  = ~sel_q[2] & sel_q[1];
  wire sclk_fall = sclk_q[2] & ~sclk_q[1];
  wire sclk_rise = ~sclk_q[2] & sclk_q[1];

  // --------------------------------------------------------------------------
  // frame shifter
  // --------------------------------------------------------------------------
  reg  [15:0] shift_q;
  reg  [4:0]  bit_cnt_q;
  reg         active_q;
  reg         done_q;
  wire        push;
  wire [15:0] push_word;

  // one push per frame: sixteenth rise, or select rise on a partial word
  assign push = active_q & ~done_q &
                ((sclk_rise & (bit_cnt_q == `DL_FRAME_BITS)) |
                 (sel_rise & (bit_cnt_q != 5'h00)));
  assign push_word = shift_q;

  always @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      shift_q   <= 16'h0000;
      bit_cnt_q <= 5'h00;
      active_q  <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      if (sel_fall) begin
        bit_cnt_q <= 5'h00;
        shift_q   <= 16'h0000;
        active_q  <= 1'b1;
        done_q    <= 1'b0;
      end else if (sel_rise) begin
        active_q  <= 1'b0;
        done_q    <= 1'b0;
      end else if (active_q) begin
        // bits past the sixteenth wait for the next select fall
        if (sclk_fall && !done_q && bit_cnt_q != `DL_FRAME_BITS) begin
          shift_q   <= {shift_q[14:0], din_q[2]};
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (push) begin
          done_q <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // two-entry word buffer
  // --------------------------------------------------------------------------
  reg  [15:0]        fifo_mem [0:FIFO_DEPTH-1];
  reg  [FIFO_AW-1:0] wr_ptr_q;
  reg  [FIFO_AW-1:0] rd_ptr_q;
  reg  [FIFO_AW:0]   fifo_cnt_q;
  reg                freeze_q;
  wire               fifo_full  = (fifo_cnt_q == FIFO_DEPTH[FIFO_AW:0]);
  wire               fifo_valid = (fifo_cnt_q != {(FIFO_AW+1){1'b0}});
  wire               fifo_ready = ~fifo_full;
  wire               do_push    = push & fifo_ready;
  wire               do_pop     = fifo_valid & ~freeze_q;
  wire [15:0]        pop_word   = fifo_mem[rd_ptr_q];

  // freeze holds words back; a word pushed while full is lost
  // count runs 0..FIFO_DEPTH, one bit wider than the pointers
  integer i;

  always @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      wr_ptr_q   <= {FIFO_AW{1'b0}};
      rd_ptr_q   <= {FIFO_AW{1'b0}};
      fifo_cnt_q <= {(FIFO_AW+1){1'b0}};
      for (i = 0; i < FIFO_DEPTH; i = i + 1) begin
        fifo_mem[i] <= 16'h0000;
      end
    end else begin
      if (do_push) begin
        fifo_mem[wr_ptr_q] <= push_word;
        wr_ptr_q           <= wr_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        fifo_cnt_q <= fifo_cnt_q + {{FIFO_AW{1'b0}}, 1'b1};
      end else if (!do_push && do_pop) begin
        fifo_cnt_q <= fifo_cnt_q - {{FIFO_AW{1'b0}}, 1'b1};
      end
    end
  end

  // --------------------------------------------------------------------------
  // latches
  // --------------------------------------------------------------------------
  reg  [11:0] dac_a_q;
  reg  [11:0] dac_b_q;
  reg  [11:0] hold_q;
  reg  [1:0]  ref_sel_q;
  reg         ref_int_q;
  reg         ref_high_q;
  reg         fast_q;
  reg         pwr_q;
  wire [1:0]  tgt  = {pop_word[`DL_SEL_HI_BIT], pop_word[`DL_SEL_LO_BIT]};
  wire [11:0] data = pop_word[11:0];

  always @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      dac_a_q    <= `DL_CODE_RST;
      dac_b_q    <= `DL_CODE_RST;
      hold_q     <= `DL_CODE_RST;
      ref_sel_q  <= 2'h0;
      ref_int_q  <= 1'b0;
      ref_high_q <= 1'b0;
      fast_q     <= 1'b0;
      pwr_q      <= 1'b0;
    end else if (do_pop) begin
      // speed and power follow every frame, whatever its target
      fast_q <= pop_word[`DL_FAST_BIT];
      pwr_q  <= pop_word[`DL_PWR_BIT];
      case (tgt)
        `DL_TGT_DAC_B: begin
          dac_b_q <= data;
          hold_q  <= data;
        end
        `DL_TGT_HOLD: begin
          hold_q <= data;
        end
        `DL_TGT_DAC_A: begin
          dac_a_q <= data;
          dac_b_q <= hold_q;
        end
        `DL_TGT_CTRL: begin
          // control data bits 11..2 carry nothing
          ref_sel_q  <= data[1:0];
          ref_int_q  <= data[1] ^ data[0];
          ref_high_q <= data[1] & ~data[0];
        end
        default: begin
          hold_q <= hold_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------------
  // one wait state: pready is raised in the second access cycle
  // only ctrl and the stat overflow flag take writes; the rest read only
  // read data is zero outside the answer cycle, so no stale word leaks
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg         ovf_q;
  reg  [31:0] rd_mux;
  reg         hit;
  wire        acc = psel_i & penable_i & ~pready_q;
  wire        wr  = acc & pwrite_i;

  always @* begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    case (paddr_i)
      `DL_CTRL_OFS: rd_mux[`DL_CTRL_FREEZE] = freeze_q;
      `DL_STAT_OFS: rd_mux[`DL_STAT_CNT_LO+FIFO_AW:0] =
                      {fifo_cnt_q, active_q, ovf_q};
      `DL_DACA_OFS: rd_mux[11:0] = dac_a_q;
      `DL_DACB_OFS: rd_mux[11:0] = dac_b_q;
      `DL_HOLD_OFS: rd_mux[11:0] = hold_q;
      `DL_CFG_OFS:  rd_mux[`DL_CFG_REF_HIGH:0] =
                      {ref_high_q, ref_int_q, pwr_q, fast_q, ref_sel_q};
      default:      hit = 1'b0;
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_b_q) begin
    if (!rst_b_q) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      freeze_q  <= `DL_CTRL_RST;
      ovf_q     <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~hit;
      prdata_q  <= (acc && !pwrite_i) ? rd_mux : 32'h0000_0000;
      if (wr && paddr_i == `DL_CTRL_OFS) begin
        freeze_q <= pwdata_i[`DL_CTRL_FREEZE];
      end
      // a word lost to a full buffer beats a clear in the same cycle
      if (push && !fifo_ready) begin
        ovf_q <= 1'b1;
      end else if (wr && paddr_i == `DL_STAT_OFS && pwdata_i[`DL_STAT_OVF]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // straight from flops: no logic between register and pin
  assign prdata_o         = prdata_q;
  assign pready_o         = pready_q;
  assign pslverr_o        = pslverr_q;
  assign dac_a_code_o     = dac_a_q;
  assign dac_b_code_o     = dac_b_q;
  assign fast_settle_o    = fast_q;
  assign power_down_o     = pwr_q;
  assign ref_source_sel_o = ref_sel_q;
  assign ref_internal_o   = ref_int_q;
  assign ref_high_o       = ref_high_q;

endmodule // dual_dac_frame_loader

// >>> verif/dac_serial_host.sv
// serial host model driving select, clock and data of the frame loader
`timescale 1ns/10ps
module dac_serial_host (
  input  wire  ref_clk_i,
  output logic sel_b_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    sel_b_o = 1'b1;
    sclk_o  = 1'b1;
    din_o   = 1'b0;
  end
  // sclk idles high so each bit ends on a rise; en low sends stray clocks only
  task automatic xfer(input logic [15:0] w, input int nb, input int gap, input bit en);
    @(posedge ref_clk_i) sel_b_o <= !en;
    repeat (8) @(posedge ref_clk_i);
    for (int i = 0; i < nb; i++) begin
      if (i == 8) repeat (gap) @(posedge ref_clk_i);
      din_o <= w[15-i];
      repeat (3) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      @(posedge ref_clk_i);
    end
    repeat (4) @(posedge ref_clk_i);
    sel_b_o <= 1'b1;
    // released line must not keep showing the last bit
    din_o   <= !din_o;
  endtask
endmodule // dac_serial_host

// >>> verif/dac_loader_chk_sva.sv
// port assertions for the dual dac frame loader
`timescale 1ns/10ps
module dac_loader_chk (
  input wire        ref_clk_i,
  input wire        rst_b_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [11:0] dac_a_code_o,
  input wire [11:0] dac_b_code_o,
  input wire [1:0]  ref_source_sel_o,
  input wire        ref_internal_o,
  input wire        ref_high_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_access; psel_i && penable_i && !pready_o; endsequence
  sequence s_answer; pready_o ##1 !pready_o; endsequence
  a_ready_next: assert property (s_access |=> s_answer)
    else $error("apb answer not one cycle pulse after access");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_first_wait: assert property ($rose(psel_i && penable_i) |-> !pready_o)
    else $error("no wait state");
  a_err_qual: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside answer");
  // reset itself is the condition here, so no disable
  a_reset_clear: assert property (disable iff (1'b0) !rst_b_i |-> dac_a_code_o == 12'h000
    && dac_b_code_o == 12'h000 && ref_source_sel_o == 2'h0 && !pready_o)
    else $error("outputs not cleared in reset");
  a_ref_internal: assert property (ref_internal_o == (ref_source_sel_o == 2'h1 ||
    ref_source_sel_o == 2'h2)) else $error("internal reference decode");
  a_ref_high: assert property (ref_high_o == (ref_source_sel_o == 2'h2))
    else $error("high reference decode");
endmodule // dac_loader_chk

bind dual_dac_frame_loader dac_loader_chk chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .dac_a_code_o(dac_a_code_o), .dac_b_code_o(dac_b_code_o),
  .ref_source_sel_o(ref_source_sel_o), .ref_internal_o(ref_internal_o), .ref_high_o(ref_high_o));

// >>> verif/dual_dac_serial_frame_loader_tb_top.sv
// self-checking bench for the dual dac frame loader
`timescale 1ns/10ps
`include "dac_loader_regs.vh"
module dual_dac_serial_frame_loader_tb_top;
  logic        clk = 1'b0;
  logic        rst_b;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, sel_b, sclk, din, fast, power_down_bit, rint, rhigh;
  logic [11:0] dac_a, dac_b;
  logic [1:0]  rsel;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #10 clk = !clk;
  dual_dac_frame_loader uut (.ref_clk_i(clk), .rst_b_i(rst_b), .sel_b_i(sel_b), .sclk_i(sclk),
    .din_i(din), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .dac_a_code_o(dac_a), .dac_b_code_o(dac_b), .fast_settle_o(fast), .power_down_o(power_down_bit),
    .ref_source_sel_o(rsel), .ref_internal_o(rint), .ref_high_o(rhigh));
  dac_serial_host host (.ref_clk_i(clk), .sel_b_o(sel_b), .sclk_o(sclk), .din_o(din));
  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h0000_0001);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  // one frame, then dac ports, holding latch and config compared
  task automatic step(input logic [15:0] w, input int nb, input int gap, input bit en,
                      input logic [11:0] a, input logic [11:0] b, input logic [11:0] h,
                      input logic [5:0] c);
    host.xfer(w, nb, gap, en);
    repeat (12) @(posedge clk);
    chk(32'(dac_a), 32'(a));
    chk(32'(dac_b), 32'(b));
    chk(32'({rhigh, rint, power_down_bit, fast, rsel}), 32'(c));
    rd(`DL_HOLD_OFS, 32'(h), 1'b0);
    rd(`DL_CFG_OFS, 32'(c), 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    step(16'hFFFF, 16, 0, 1'b0, 12'h000, 12'h000, 12'h000, 6'h00);
    step(16'hD002, 16, 0, 1'b1, 12'h000, 12'h000, 12'h000, 6'h36);
    step(16'h1ABC, 16, 0, 1'b1, 12'h000, 12'h000, 12'hABC, 6'h32);
    step(16'h0123, 16, 0, 1'b1, 12'h000, 12'h123, 12'h123, 6'h32);
    step(16'h5456, 16, 0, 1'b1, 12'h000, 12'h123, 12'h456, 6'h36);
    step(16'hA9E7, 16, 0, 1'b1, 12'h9E7, 12'h456, 12'h456, 6'h3A);
    step(16'hF001, 16, 0, 1'b1, 12'h9E7, 12'h456, 12'h456, 6'h1D);
    step(16'hBFFF, 16, 0, 1'b1, 12'h9E7, 12'h456, 12'h456, 6'h0B);
    step(16'h9000, 16, 0, 1'b1, 12'h9E7, 12'h456, 12'h456, 6'h00);
    step(16'h8FFF, 16, 0, 1'b1, 12'hFFF, 12'h456, 12'h456, 6'h00);
    step(16'h0777, 16, 40, 1'b1, 12'hFFF, 12'h777, 12'h777, 6'h00);
    step(16'hA5A5, 12, 0, 1'b1, 12'hFFF, 12'hA5A, 12'hA5A, 6'h00);
    step(16'h1321, 16, 0, 1'b1, 12'hFFF, 12'hA5A, 12'h321, 6'h00);
    step(16'hFFFF, 16, 0, 1'b0, 12'hFFF, 12'hA5A, 12'h321, 6'h00);
    // frozen buffer: two words kept, third dropped
    wr(`DL_CTRL_OFS, 32'h0000_0001);
    rd(`DL_CTRL_OFS, 32'h0000_0001, 1'b0);
    for (int i = 1; i < 4; i++) begin
      step(16'(i * 16'h0111), 16, 0, 1'b1, 12'hFFF, 12'hA5A, 12'h321, 6'h00);
    end
    rd(`DL_STAT_OFS, 32'h0000_0009, 1'b0);
    wr(`DL_STAT_OFS, 32'h0000_0001);
    rd(`DL_STAT_OFS, 32'h0000_0008, 1'b0);
    wr(`DL_CTRL_OFS, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(32'(dac_b), 32'h0000_0222);
    rd(`DL_HOLD_OFS, 32'h0000_0222, 1'b0);
    rd(`DL_STAT_OFS, 32'h0000_0000, 1'b0);
    rd(12'h018, 32'h0000_0000, 1'b1);
    wr(`DL_DACA_OFS, 32'h0000_0005);
    rd(`DL_DACA_OFS, 32'h0000_0FFF, 1'b0);
    // second reset in mid-run: loaded latches must clear
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(dac_a), 32'h0000_0000);
    chk(32'(dac_b), 32'h0000_0000);
    rd(`DL_HOLD_OFS, 32'h0000_0000, 1'b0);
    rd(`DL_STAT_OFS, 32'h0000_0000, 1'b0);
    test_done();
  end
endmodule // dual_dac_serial_frame_loader_tb_top
